// [design/pad_comp_bypass.v]
// Contract
// [R1] Hold data P drive, 0000 weakest, to pads only when data bypass set.
// [R2] Hold data N drive, 0000 weakest, to pads only when data bypass set.
// [R3] Data bypass set: auto result disconnected, programmed drive goes to data pads.
// [R4] Data rise slew always applied, independent of data bypass.
// [R5] Data fall slew always applied, independent of data bypass.
// [R6] Hold strobe P drive, applied only when strobe bypass set.
// [R7] Hold strobe N drive, applied only when strobe bypass set.
// [R8] Strobe bypass set: programmed strobe drive goes directly to strobe pads.
// [R9] Strobe rise slew always applied, independent of strobe bypass.
// [R10] Strobe fall slew always applied, independent of strobe bypass.
// [R11] Only three bypass combinations; data bypassed with strobes compensated is illegal.
// [R12] Data bypass values also drive strobe pads until strobe values written.
// [R13] Auto compensation takes effect only in the low-voltage signalling environment.
// [R14] Software triggers one-shot compensation after leaving bypass, before enabling port.
// [R15] Reserved bits read zero and ignore writes.
`timescale 1ns/1ns
`default_nettype none
`include "pad_comp_bypass_regs.vh"

module pad_comp_bypass
(
	// Clock, reset, enable
	input wire clk,
	input wire srst,
	input wire ce,
	// Configuration space access
	input wire cfgWrEn,
	input wire cfgRdEn,
	input wire [7:0] cfgAddr,
	input wire [3:0] cfgByteEn,
	input wire [31:0] cfgWrData,
	output reg [31:0] cfgRdData_r,
	// Signalling environment and compensation circuit
	input wire lowVoltSig,
	input wire [3:0] autoDataP,
	input wire [3:0] autoDataN,
	input wire [3:0] autoStrbP,
	input wire [3:0] autoStrbN,
	// Data pad controls
	output wire [3:0] dataPadP,
	output wire [3:0] dataPadN,
	output reg [1:0] dataRiseSlew_r,
	output reg [1:0] dataFallSlew_r,
	output wire dataCompActive,
	// Strobe pad controls
	output wire [3:0] strbPadP,
	output wire [3:0] strbPadN,
	output reg [1:0] strbRiseSlew_r,
	output reg [1:0] strbFallSlew_r,
	output wire strbCompActive,
	// Status
	output wire illegalCombo,
	output reg bypassExit_r
);

	// Register byte offset, low two bits ignored by the decode
	localparam [7:0] REG_OFFSET = `PDBC_OFFSET;

	// Register fields
	reg [3:0] data_pdrive_override_r;
	reg [3:0] data_ndrive_override_r;
	reg data_pad_bypass_en_r;
	reg [1:0] data_rise_slew_r;
	reg [1:0] data_fall_slew_r;
	reg [3:0] strobe_pdrive_override_r;
	reg [3:0] strobe_ndrive_override_r;
	reg strobe_pad_bypass_en_r;
	reg [1:0] strobe_rise_slew_r;
	reg [1:0] strobe_fall_slew_r;
	reg strbValsWritten_r;
	wire hit;
	wire wrHit;
	wire [31:0] regValue;
	wire [31:0] wrMerged;
	wire strbBypass;
	wire [3:0] strbSrcP;
	wire [3:0] strbSrcN;

	// Merge byte lanes of a write into the current value
	function [31:0] mergeBytes;
		input [31:0] cur;
		input [31:0] wd;
		input [3:0] be;
		integer i;
		begin
			mergeBytes = cur;
			for (i = 0; i < 4; i = i + 1)
				if (be[i])
					mergeBytes[i*8 +: 8] = wd[i*8 +: 8];
		end
	endfunction

	// Address decode
	assign hit = (cfgAddr[7:2] == REG_OFFSET[7:2]);
	assign wrHit = cfgWrEn & hit & ce;

	// Readback image, reserved bits zero
	assign regValue = {data_pdrive_override_r, data_ndrive_override_r, data_pad_bypass_en_r, 3'h0,
		data_rise_slew_r, data_fall_slew_r, strobe_pdrive_override_r, strobe_ndrive_override_r,
		strobe_pad_bypass_en_r, 3'h0, strobe_rise_slew_r, strobe_fall_slew_r}; // R15

	// Reserved bits masked off the write
	assign wrMerged = mergeBytes(regValue, cfgWrData, cfgByteEn) & `PDBC_WR_MASK; // R15

	// Register write
	always @(posedge clk)
	begin
		if (srst)
		begin
			data_pdrive_override_r <= `PDBC_DRV_RESET;
			data_ndrive_override_r <= `PDBC_DRV_RESET;
			data_pad_bypass_en_r <= `PDBC_BYP_RESET;
			data_rise_slew_r <= `PDBC_SLEW_RESET;
			data_fall_slew_r <= `PDBC_SLEW_RESET;
			strobe_pdrive_override_r <= `PDBC_DRV_RESET;
			strobe_ndrive_override_r <= `PDBC_DRV_RESET;
			strobe_pad_bypass_en_r <= `PDBC_BYP_RESET;
			strobe_rise_slew_r <= `PDBC_SLEW_RESET;
			strobe_fall_slew_r <= `PDBC_SLEW_RESET;
		end
		else if (wrHit)
		begin
			data_pdrive_override_r <= wrMerged[`PDBC_DATA_PDRV_HI:`PDBC_DATA_PDRV_LO]; // R1
			data_ndrive_override_r <= wrMerged[`PDBC_DATA_NDRV_HI:`PDBC_DATA_NDRV_LO]; // R2
			data_pad_bypass_en_r <= wrMerged[`PDBC_DATA_BYP_BIT]; // R3
			data_rise_slew_r <= wrMerged[`PDBC_DATA_RSLEW_HI:`PDBC_DATA_RSLEW_LO]; // R4
			data_fall_slew_r <= wrMerged[`PDBC_DATA_FSLEW_HI:`PDBC_DATA_FSLEW_LO]; // R5
			strobe_pdrive_override_r <= wrMerged[`PDBC_STRB_PDRV_HI:`PDBC_STRB_PDRV_LO]; // R6
			strobe_ndrive_override_r <= wrMerged[`PDBC_STRB_NDRV_HI:`PDBC_STRB_NDRV_LO]; // R7
			strobe_pad_bypass_en_r <= wrMerged[`PDBC_STRB_BYP_BIT]; // R8
			strobe_rise_slew_r <= wrMerged[`PDBC_STRB_RSLEW_HI:`PDBC_STRB_RSLEW_LO]; // R9
			strobe_fall_slew_r <= wrMerged[`PDBC_STRB_FSLEW_HI:`PDBC_STRB_FSLEW_LO]; // R10
		end
	end

	// Tracks whether strobe drive values were written since data bypass values
	always @(posedge clk)
	begin
		if (srst)
			strbValsWritten_r <= 1'b1;
		else if (wrHit)
		begin
			if (cfgByteEn[1])
				strbValsWritten_r <= 1'b1; // R12
			else if (cfgByteEn[3] | (cfgByteEn[2] & cfgWrData[`PDBC_DATA_BYP_BIT]))
				strbValsWritten_r <= 1'b0; // R12
		end
	end

	// Slew fields reach the pads whatever the bypass bits say
	always @(posedge clk)
	begin
		if (srst)
		begin
			dataRiseSlew_r <= `PDBC_SLEW_RESET;
			dataFallSlew_r <= `PDBC_SLEW_RESET;
			strbRiseSlew_r <= `PDBC_SLEW_RESET;
			strbFallSlew_r <= `PDBC_SLEW_RESET;
		end
		else if (ce)
		begin
			dataRiseSlew_r <= data_rise_slew_r; // R4
			dataFallSlew_r <= data_fall_slew_r; // R5
			strbRiseSlew_r <= strobe_rise_slew_r; // R9
			strbFallSlew_r <= strobe_fall_slew_r; // R10
		end
	end

	// Unsupported mix flagged; strobes then follow the data bypass values
	assign illegalCombo = data_pad_bypass_en_r & ~strobe_pad_bypass_en_r; // R11
	assign strbBypass = strobe_pad_bypass_en_r | data_pad_bypass_en_r; // R11

	// Strobe source: data values until strobe values written
	assign strbSrcP = (data_pad_bypass_en_r & (~strbValsWritten_r | ~strobe_pad_bypass_en_r)) ?
		data_pdrive_override_r : strobe_pdrive_override_r; // R12
	assign strbSrcN = (data_pad_bypass_en_r & (~strbValsWritten_r | ~strobe_pad_bypass_en_r)) ?
		data_ndrive_override_r : strobe_ndrive_override_r; // R12

	// Data pad strength selection
	pad_drive_select dataSel
	(
		.clk(clk),
		.srst(srst),
		.ce(ce),
		.bypassEn(data_pad_bypass_en_r), // R3
		.lowVoltSig(lowVoltSig), // R13
		.overP(data_pdrive_override_r), // R1
		.overN(data_ndrive_override_r), // R2
		.autoP(autoDataP),
		.autoN(autoDataN),
		.padP_r(dataPadP),
		.padN_r(dataPadN),
		.compActive(dataCompActive)
	);

	// Strobe pad strength selection
	pad_drive_select strbSel
	(
		.clk(clk),
		.srst(srst),
		.ce(ce),
		.bypassEn(strbBypass), // R8
		.lowVoltSig(lowVoltSig), // R13
		.overP(strbSrcP), // R6
		.overN(strbSrcN), // R7
		.autoP(autoStrbP),
		.autoN(autoStrbN),
		.padP_r(strbPadP),
		.padN_r(strbPadN),
		.compActive(strbCompActive)
	);

	// Pulse when a write leaves bypass, so firmware can start compensation
	always @(posedge clk)
	begin
		if (srst)
			bypassExit_r <= 1'b0;
		else if (ce)
			bypassExit_r <= wrHit & ((data_pad_bypass_en_r & ~wrMerged[`PDBC_DATA_BYP_BIT]) |
				(strobe_pad_bypass_en_r & ~wrMerged[`PDBC_STRB_BYP_BIT])); // R14
	end

	// Registered read, zero for other offsets
	always @(posedge clk)
	begin
		if (srst)
			cfgRdData_r <= 32'h00000000;
		else if (ce)
			cfgRdData_r <= (cfgRdEn & hit) ? regValue : 32'h00000000;
	end

endmodule

`default_nettype wire

// [design/pad_comp_bypass_regs.vh]
`ifndef PAD_COMP_BYPASS_REGS_VH
`define PAD_COMP_BYPASS_REGS_VH

// Configuration space offset of the bypass control register
`define PDBC_OFFSET 8'hb8

// Field positions
`define PDBC_DATA_PDRV_HI 31
`define PDBC_DATA_PDRV_LO 28
`define PDBC_DATA_NDRV_HI 27
`define PDBC_DATA_NDRV_LO 24
`define PDBC_DATA_BYP_BIT 23
`define PDBC_DATA_RSLEW_HI 19
`define PDBC_DATA_RSLEW_LO 18
`define PDBC_DATA_FSLEW_HI 17
`define PDBC_DATA_FSLEW_LO 16
`define PDBC_STRB_PDRV_HI 15
`define PDBC_STRB_PDRV_LO 12
`define PDBC_STRB_NDRV_HI 11
`define PDBC_STRB_NDRV_LO 8
`define PDBC_STRB_BYP_BIT 7
`define PDBC_STRB_RSLEW_HI 3
`define PDBC_STRB_RSLEW_LO 2
`define PDBC_STRB_FSLEW_HI 1
`define PDBC_STRB_FSLEW_LO 0

// Writable bits; everything else is reserved and reads zero
`define PDBC_WR_MASK 32'hff8fff8f

// Reset values
`define PDBC_RESET 32'h00800080
`define PDBC_DRV_RESET 4'h0
`define PDBC_SLEW_RESET 2'h0
`define PDBC_BYP_RESET 1'h1

`endif

// [design/pad_drive_select.v]
`timescale 1ns/1ns
`default_nettype none
`include "pad_comp_bypass_regs.vh"

module pad_drive_select
(
	// Clock, reset, enable
	input wire clk,
	input wire srst,
	input wire ce,
	// Selection
	input wire bypassEn,
	input wire lowVoltSig,
	// Programmed and compensated strengths
	input wire [3:0] overP,
	input wire [3:0] overN,
	input wire [3:0] autoP,
	input wire [3:0] autoN,
	// Pad strengths
	output reg [3:0] padP_r,
	output reg [3:0] padN_r,
	output wire compActive
);

	// Compensation only acts in the low-voltage environment
	assign compActive = ~bypassEn & lowVoltSig;

	// Programmed value when bypassed, compensated value in the low-voltage environment; hold otherwise
	always @(posedge clk)
	begin
		if (srst)
		begin
			padP_r <= `PDBC_DRV_RESET;
			padN_r <= `PDBC_DRV_RESET;
		end
		else if (ce)
		begin
			if (bypassEn)
			begin
				padP_r <= overP;
				padN_r <= overN;
			end
			else if (lowVoltSig)
			begin
				padP_r <= autoP;
				padN_r <= autoN;
			end
		end
	end

endmodule

`default_nettype wire

// [verification/comp_model.sv]
`timescale 1ns/1ns
`default_nettype none
module comp_model
(
	// Result select
	input wire logic alt,
	// Compensation results
	output logic [3:0] dataP,
	output logic [3:0] dataN,
	output logic [3:0] strbP,
	output logic [3:0] strbN
);
	// Two fixed results; the pads must ignore them unless compensated
	assign dataP = alt ? 4'h3 : 4'h6;
	assign dataN = ~dataP;
	assign strbP = dataN;
	assign strbN = dataP;
endmodule
`default_nettype wire

// [verification/pad_comp_bypass_chk.sv]
`timescale 1ns/1ns
`default_nettype none
module pad_comp_bypass_chk
(
	// Clock and access
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic cfgWrEn,
	input wire logic cfgRdEn,
	input wire logic [7:0] cfgAddr,
	input wire logic [3:0] cfgByteEn,
	input wire logic [31:0] cfgWrData,
	input wire logic [31:0] cfgRdData_r,
	input wire logic lowVoltSig,
	// Pad side
	input wire logic [3:0] dataPadP,
	input wire logic [3:0] dataPadN,
	input wire logic [1:0] dataRiseSlew_r,
	input wire logic [1:0] dataFallSlew_r,
	input wire logic dataCompActive,
	input wire logic [3:0] strbPadP,
	input wire logic [3:0] strbPadN,
	input wire logic [1:0] strbRiseSlew_r,
	input wire logic [1:0] strbFallSlew_r,
	input wire logic strbCompActive,
	input wire logic illegalCombo,
	input wire logic bypassExit_r
);
	// Decode of accesses that reach the register
	wire logic hit = cfgAddr[7:2] == 6'h2e;
	wire logic wr = ce && cfgWrEn && hit;
	wire logic all = wr && cfgByteEn == 4'hf;
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	AST_RDZERO: assert property (
		ce && !(cfgRdEn && hit) |=> cfgRdData_r == 32'h0)
		else $error("read data not idle");
	AST_RSV: assert property (
		ce && cfgRdEn && hit |=> (cfgRdData_r & 32'h00700070) == 32'h0)
		else $error("reserved set");
	AST_DSLEW: assert property (
		wr && cfgByteEn[2] ##1 ce |=> {dataRiseSlew_r, dataFallSlew_r} == $past(cfgWrData[19:16], 2))
		else $error("data slew wrong");
	AST_SSLEW: assert property (
		wr && cfgByteEn[0] ##1 ce |=> {strbRiseSlew_r, strbFallSlew_r} == $past(cfgWrData[3:0], 2))
		else $error("strobe slew wrong");
	AST_DBYP: assert property (
		all && cfgWrData[23] ##1 ce |=> {dataPadP, dataPadN} == $past(cfgWrData[31:24], 2))
		else $error("data drive wrong");
	AST_SBYP: assert property (
		all && cfgWrData[7] ##1 ce |=> {strbPadP, strbPadN} == $past(cfgWrData[15:8], 2))
		else $error("strobe drive wrong");
	AST_TRACK: assert property (
		all && cfgWrData[23] && !cfgWrData[7] ##1 ce |=> {strbPadP, strbPadN} == $past(cfgWrData[31:24], 2))
		else $error("strobe not tracking");
	AST_ILL: assert property (
		all |=> illegalCombo == ($past(cfgWrData[23]) && !$past(cfgWrData[7])))
		else $error("combo flag");
	AST_COMP: assert property (
		all |=> dataCompActive == (!$past(cfgWrData[23]) && lowVoltSig))
		else $error("comp flag");
	AST_SCOMP: assert property (
		all |=> strbCompActive == (!$past(cfgWrData[23]) && !$past(cfgWrData[7]) && lowVoltSig))
		else $error("strobe comp flag");
	AST_EXIT: assert property (
		$rose(bypassExit_r) |-> $past(wr))
		else $error("exit pulse without write");
	// Main scenarios
	COV_WR: cover property (all);
	COV_ILL: cover property (illegalCombo);
	COV_EXIT: cover property (bypassExit_r);
endmodule
bind pad_comp_bypass pad_comp_bypass_chk u_pad_comp_bypass_chk (.clk(clk), .srst(srst), .ce(ce), .cfgWrEn(cfgWrEn),
	.cfgRdEn(cfgRdEn), .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData), .cfgRdData_r(cfgRdData_r),
	.lowVoltSig(lowVoltSig), .dataPadP(dataPadP), .dataPadN(dataPadN), .dataRiseSlew_r(dataRiseSlew_r),
	.dataFallSlew_r(dataFallSlew_r), .dataCompActive(dataCompActive), .strbPadP(strbPadP), .strbPadN(strbPadN),
	.strbRiseSlew_r(strbRiseSlew_r), .strbFallSlew_r(strbFallSlew_r), .strbCompActive(strbCompActive),
	.illegalCombo(illegalCombo),
	.bypassExit_r(bypassExit_r));
`default_nettype wire

// [verification/tb.sv]
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic clk, srst, ce, cfgWrEn, cfgRdEn, lowVoltSig, alt, dComp, sComp, illegal, bypExit;
	logic [7:0] cfgAddr;
	logic [3:0] cfgByteEn, aDP, aDN, aSP, aSN, dP, dN, sP, sN;
	logic [31:0] cfgWrData, cfgRdData_r;
	logic [1:0] dRise, dFall, sRise, sFall;
	int bad_count, total_checks;
	comp_model u_comp_model (.alt(alt), .dataP(aDP), .dataN(aDN), .strbP(aSP), .strbN(aSN));
	pad_comp_bypass u_pad_comp_bypass (.clk(clk), .srst(srst), .ce(ce), .cfgWrEn(cfgWrEn), .cfgRdEn(cfgRdEn),
		.cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData), .cfgRdData_r(cfgRdData_r),
		.lowVoltSig(lowVoltSig), .autoDataP(aDP), .autoDataN(aDN), .autoStrbP(aSP), .autoStrbN(aSN),
		.dataPadP(dP), .dataPadN(dN), .dataRiseSlew_r(dRise), .dataFallSlew_r(dFall), .dataCompActive(dComp),
		.strbPadP(sP), .strbPadN(sN), .strbRiseSlew_r(sRise), .strbFallSlew_r(sFall), .strbCompActive(sComp),
		.illegalCombo(illegal), .bypassExit_r(bypExit));
	// Report one comparison
	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp)
		begin
			$display("Error %s expected %h seen %h", name, exp, got);
			bad_count++;
		end
	endtask
	// Register write, returns once the pads have settled
	task wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
		@(posedge clk);
		#1;
		cfgWrEn = 1;
		cfgAddr = a;
		cfgByteEn = be;
		cfgWrData = d;
		@(posedge clk);
		#1;
		cfgWrEn = 0;
		repeat (2) @(posedge clk);
		#1;
	endtask
	// Register read and compare
	task rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		#1;
		cfgRdEn = 1;
		cfgAddr = a;
		@(posedge clk);
		#1;
		cfgRdEn = 0;
		chk("readback", exp, cfgRdData_r);
	endtask
	task results;
		$display("Mismatches %0d of %0d checks", bad_count, total_checks);
		if (bad_count == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Every field set, reserved bits stay clear
	task t_full;
		wr(8'hb8, 4'hf, 32'hffffffff);
		rd(8'hb8, 32'hff8fff8f);
		chk("data drive", 32'hff, {24'h0, dP, dN});
		chk("strobe drive", 32'hff, {24'h0, sP, sN});
		chk("slews", 32'hff, {24'h0, dRise, dFall, sRise, sFall});
	endtask
	// Strobe pads follow data values until strobe lane written
	task t_track;
		wr(8'hb8, 4'hf, 32'ha5803c80);
		chk("strobe drive", 32'h3c, {24'h0, sP, sN});
		wr(8'hb8, 4'hc, 32'h96800000);
		chk("strobe drive", 32'h96, {24'h0, sP, sN});
		wr(8'hb8, 4'h3, 32'h00003c80);
		chk("strobe drive", 32'h3c, {24'h0, sP, sN});
		wr(8'hb8, 4'h1, 32'h0);
		chk("illegal", 32'h1, {31'h0, illegal});
		chk("strobe drive", 32'h96, {24'h0, sP, sN});
	endtask
	// Illegal mix, then a write that leaves bypass
	task t_exit;
		wr(8'hb8, 4'hf, 32'h7b800000);
		chk("illegal", 32'h1, {31'h0, illegal});
		chk("strobe drive", 32'h7b, {24'h0, sP, sN});
		@(posedge clk);
		#1;
		cfgWrEn = 1;
		cfgByteEn = 4'h4;
		cfgWrData = 32'h0;
		@(posedge clk);
		#1;
		cfgWrEn = 0;
		chk("bypass exit", 32'h1, {31'h0, bypExit});
		@(posedge clk);
		#1;
		chk("bypass exit", 32'h0, {31'h0, bypExit});
		chk("illegal", 32'h0, {31'h0, illegal});
	endtask
	// Compensation only at low-voltage signalling, then unmapped access
	task t_auto;
		lowVoltSig = 1;
		wr(8'hb8, 4'hf, 32'h0);
		repeat (4) @(posedge clk);
		#1;
		chk("data drive", 32'h69, {24'h0, dP, dN});
		chk("comp active", 32'h1, {31'h0, dComp});
		chk("strobe comp active", 32'h1, {31'h0, sComp});
		chk("strobe auto drive", 32'h96, {24'h0, sP, sN});
		lowVoltSig = 0;
		alt = 1;
		repeat (4) @(posedge clk);
		#1;
		chk("data drive", 32'h69, {24'h0, dP, dN});
		wr(8'hb4, 4'hf, 32'hffffffff);
		rd(8'hb8, 32'h0);
		rd(8'hb4, 32'h0);
	endtask
	initial
	begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	// Watchdog
	initial
	begin
		#20000;
		bad_count++;
		results();
	end
	initial
	begin
		{srst, ce, cfgWrEn, cfgRdEn, lowVoltSig, alt} = 6'h30;
		{cfgAddr, cfgByteEn, cfgWrData} = 44'h0;
		bad_count = 0;
		total_checks = 0;
		repeat (3) @(posedge clk);
		#1;
		srst = 0;
		rd(8'hb8, 32'h00800080);
		t_full();
		t_track();
		t_exit();
		t_auto();
		results();
	end
endmodule
`default_nettype wire
